// *** core/pmeg_edge_cmp.sv ***
// Purpose: Set/reset edge comparator for one generated signal
// Assumes: Targets stable over a period
// Notes:   Rise and fall matching in one cycle gives a fall
module pmeg_edge_cmp
    import pmeg_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         en_i,
    input  wire logic [W-1:0] count_i,
    input  wire logic [W-1:0] rise_i,
    input  wire logic [W-1:0] fall_i,
    output logic              level_o
);
    typedef struct packed {
        logic level;
    } pmeg_cmp_state_t;

    pmeg_cmp_state_t state_reg;
    pmeg_cmp_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (!en_i) begin
            state_next.level = 1'b0;
        end else if (count_i == fall_i) begin
            state_next.level = 1'b0;
        end else if (count_i == rise_i) begin
            state_next.level = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_o = state_reg.level;
endmodule // pmeg_edge_cmp

// *** core/pmeg_pkg.sv ***
// Purpose: Shared constants for the PWM mode edge generator
// Assumes: 32-bit classic Wishbone access
// Notes:   Offsets are byte addresses
package pmeg_pkg;

    // ==========================================================
    // Widths and timing
    // ==========================================================
    localparam int CNT_W      = 16;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] PERIOD_OFS  = 8'h04;
    localparam logic [7:0] EVENT1_OFS  = 8'h08;
    localparam logic [7:0] EVENT2_OFS  = 8'h0C;
    localparam logic [7:0] EVENT3_OFS  = 8'h10;
    localparam logic [7:0] EVENT4_OFS  = 8'h14;
    localparam logic [7:0] ADJ_A_OFS   = 8'h18;
    localparam logic [7:0] ADJ_B_OFS   = 8'h1C;
    localparam logic [7:0] ADAPT_OFS   = 8'h20;
    localparam logic [7:0] PHASE_OFS   = 8'h24;
    localparam logic [7:0] STRIG1_OFS  = 8'h28;
    localparam logic [7:0] STRIG2_OFS  = 8'h2C;
    localparam logic [7:0] BLKA_B_OFS  = 8'h30;
    localparam logic [7:0] BLKA_E_OFS  = 8'h34;
    localparam logic [7:0] BLKB_B_OFS  = 8'h38;
    localparam logic [7:0] BLKB_E_OFS  = 8'h3C;
    localparam logic [7:0] STATUS_OFS  = 8'h40;

    // ==========================================================
    // Control register fields
    // ==========================================================
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_MODE_LSB   = 1;
    localparam int CTRL_HALF_BIT   = 3;
    localparam int CTRL_PHSRC_BIT  = 4;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] PERIOD_RST = 32'h0000_00FF;
    localparam logic [31:0] ZERO_RST   = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    typedef enum logic [1:0] {
        PMEG_NORMAL,
        PMEG_MULTI,
        PMEG_RESONANT,
        PMEG_TRIANGLE
    } pmeg_mode_t;

endpackage : pmeg_pkg

// *** core/pmeg_top.sv ***
// Purpose: Dual-output PWM edge generator with four modes behind Wishbone
// Assumes: Loop filter words synchronous to clk_i
// Notes:   Filter, adjust, adapt and mode words are latched at every period start; event words apply at once
module pmeg_top
    import pmeg_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         cyc_i,
    input  wire logic         stb_i,
    input  wire logic         we_i,
    input  wire logic [7:0]   adr_i,
    input  wire logic [3:0]   sel_i,
    input  wire logic [31:0]  dat_i,
    output logic [31:0]       dat_o,
    output logic              ack_o,
    input  wire logic [W-1:0] filt_duty_i,
    input  wire logic [W-1:0] filt_period_i,
    output logic              output_a_o,
    output logic              output_b_o,
    output logic              adapt_trig_o,
    output logic              phase_trig_o,
    output logic              samp_trig1_o,
    output logic              samp_trig2_o,
    output logic              blank_a_o,
    output logic              blank_b_o,
    output logic              period_start_o
);
    if (W < 4 || W > 32) begin : g_bad_w
        $error("pmeg_top: W must lie in 4..32");
    end

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [31:0]  ctrl;
        logic [W-1:0] period_lim;
        logic [W-1:0] ev1;
        logic [W-1:0] ev2;
        logic [W-1:0] ev3;
        logic [W-1:0] ev4;
        logic [W-1:0] adj_a;
        logic [W-1:0] adj_b;
        logic [W-1:0] adapt;
        logic [W-1:0] phase;
        logic [W-1:0] st1;
        logic [W-1:0] st2;
        logic [W-1:0] blka_b;
        logic [W-1:0] blka_e;
        logic [W-1:0] blkb_b;
        logic [W-1:0] blkb_e;
        logic [W-1:0] count;
        logic [W-1:0] lat_duty;
        logic [W-1:0] lat_period;
        logic [W-1:0] lat_adj_a;
        logic [W-1:0] lat_adj_b;
        logic [W-1:0] lat_adapt;
        pmeg_mode_t   lat_mode;
        logic         ack;
        logic [31:0]  rdata;
        logic         adapt_trig;
        logic         phase_trig;
        logic         st1_p;
        logic         st2_p;
        logic         pstart;
    } pmeg_state_t;

    pmeg_state_t state_reg;
    pmeg_state_t state_next;

    // Byte-lane merge of one register word
    function automatic logic [W-1:0] merge(input logic [W-1:0] old_v, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] t;
        t = 32'h0000_0000;
        t[W-1:0] = old_v;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                t[8*i +: 8] = d[8*i +: 8];
            end
        end
        return t[W-1:0];
    endfunction

    function automatic logic [31:0] widen(input logic [W-1:0] v);
        logic [31:0] t;
        t = 32'h0000_0000;
        t[W-1:0] = v;
        return t;
    endfunction

    // ==========================================================
    // Edge target computation from latched values and event registers
    // ==========================================================
    logic [W-1:0] a_rise;
    logic [W-1:0] a_fall;
    logic [W-1:0] b_rise;
    logic [W-1:0] b_fall;
    logic [W-1:0] adapt_pos;
    logic         a_en;
    logic         run;
    logic [W+1:0] b_sum;
    logic [W-1:0] half_duty;
    logic [W-1:0] half_prd;
    logic [W-1:0] mean_dead;
    logic [W-1:0] res_on;
    logic         lvl_a;
    logic         lvl_b;
    logic         lvl_ba;
    logic         lvl_bb;

    assign run = state_reg.ctrl[CTRL_EN_BIT];

    always_comb begin
        half_duty = state_reg.lat_duty >> 1;
        half_prd  = state_reg.lat_period >> 1;
        b_sum     = (W+2)'(state_reg.ev3) + (W+2)'(state_reg.lat_duty) + (W+2)'(state_reg.lat_adj_b);
        // Mean of dead times A->B and B->A
        mean_dead = W'(({1'b0, state_reg.ev3 - state_reg.ev2}
                        + {1'b0, state_reg.ev1 + state_reg.lat_period - state_reg.ev4}) >> 1);
        res_on    = state_reg.lat_duty - mean_dead;
        a_en      = 1'b1;
        a_rise    = state_reg.ev1;
        a_fall    = state_reg.ev1 + state_reg.lat_duty + state_reg.lat_adj_a;
        b_rise    = a_fall + (state_reg.ev3 - state_reg.ev2);
        b_fall    = state_reg.ev4;
        adapt_pos = state_reg.ev1
                    + (state_reg.ctrl[CTRL_HALF_BIT] ? half_duty : state_reg.lat_duty)
                    + state_reg.lat_adapt;
        unique case (state_reg.lat_mode)
            PMEG_NORMAL: begin
            end
            PMEG_MULTI: begin
                b_rise = state_reg.ev3;
                // B past the period end falls next period
                b_fall = W'((b_sum > (W+2)'(state_reg.period_lim))
                            ? b_sum - (W+2)'(state_reg.period_lim) - (W+2)'(1) : b_sum);
            end
            PMEG_RESONANT: begin
                // Only A rise is tied to period start
                a_fall = state_reg.ev1 + res_on;
                b_rise = a_fall + (state_reg.ev3 - state_reg.ev2);
                b_fall = b_rise + res_on;
            end
            PMEG_TRIANGLE: begin
                a_en   = 1'b0;
                b_rise = half_prd - half_duty + state_reg.lat_adj_a;
                b_fall = half_prd + half_duty + state_reg.lat_adj_b;
            end
        endcase
    end

    // ==========================================================
    // Edge comparators
    // ==========================================================
    pmeg_edge_cmp #(.W(W)) u_out_a (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .en_i    (run && a_en),
        .count_i (state_reg.count),
        .rise_i  (a_rise),
        .fall_i  (a_fall),
        .level_o (lvl_a)
    );

    pmeg_edge_cmp #(.W(W)) u_out_b (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .en_i    (run),
        .count_i (state_reg.count),
        .rise_i  (b_rise),
        .fall_i  (b_fall),
        .level_o (lvl_b)
    );

    pmeg_edge_cmp #(.W(W)) u_blank_a (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .en_i    (run),
        .count_i (state_reg.count),
        .rise_i  (state_reg.blka_b),
        .fall_i  (state_reg.blka_e),
        .level_o (lvl_ba)
    );

    pmeg_edge_cmp #(.W(W)) u_blank_b (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .en_i    (run),
        .count_i (state_reg.count),
        .rise_i  (state_reg.blkb_b),
        .fall_i  (state_reg.blkb_e),
        .level_o (lvl_bb)
    );

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic wr;
        logic rd;
        wr = 1'b0;
        rd = 1'b0;
        state_next            = state_reg;
        state_next.ack        = 1'b0;
        state_next.adapt_trig = 1'b0;
        state_next.phase_trig = 1'b0;
        state_next.st1_p      = 1'b0;
        state_next.st2_p      = 1'b0;
        state_next.pstart     = 1'b0;

        // One wait state; ack stands one cycle
        if (cyc_i && stb_i && !state_reg.ack) begin
            state_next.ack = 1'b1;
            wr = we_i;
            rd = !we_i;
        end
        if (wr) begin
            unique case (adr_i)
                CTRL_OFS:   state_next.ctrl       = sel_i[0] ? 32'(dat_i[CTRL_PHSRC_BIT:0]) : state_reg.ctrl;
                PERIOD_OFS: state_next.period_lim = merge(state_reg.period_lim, dat_i, sel_i);
                EVENT1_OFS: state_next.ev1        = merge(state_reg.ev1, dat_i, sel_i);
                EVENT2_OFS: state_next.ev2        = merge(state_reg.ev2, dat_i, sel_i);
                EVENT3_OFS: state_next.ev3        = merge(state_reg.ev3, dat_i, sel_i);
                EVENT4_OFS: state_next.ev4        = merge(state_reg.ev4, dat_i, sel_i);
                ADJ_A_OFS:  state_next.adj_a      = merge(state_reg.adj_a, dat_i, sel_i);
                ADJ_B_OFS:  state_next.adj_b      = merge(state_reg.adj_b, dat_i, sel_i);
                ADAPT_OFS:  state_next.adapt      = merge(state_reg.adapt, dat_i, sel_i);
                PHASE_OFS:  state_next.phase      = merge(state_reg.phase, dat_i, sel_i);
                STRIG1_OFS: state_next.st1        = merge(state_reg.st1, dat_i, sel_i);
                STRIG2_OFS: state_next.st2        = merge(state_reg.st2, dat_i, sel_i);
                BLKA_B_OFS: state_next.blka_b     = merge(state_reg.blka_b, dat_i, sel_i);
                BLKA_E_OFS: state_next.blka_e     = merge(state_reg.blka_e, dat_i, sel_i);
                BLKB_B_OFS: state_next.blkb_b     = merge(state_reg.blkb_b, dat_i, sel_i);
                BLKB_E_OFS: state_next.blkb_e     = merge(state_reg.blkb_e, dat_i, sel_i);
                default: begin
                end
            endcase
        end
        if (rd) begin
            unique case (adr_i)
                CTRL_OFS:   state_next.rdata = state_reg.ctrl;
                PERIOD_OFS: state_next.rdata = widen(state_reg.period_lim);
                EVENT1_OFS: state_next.rdata = widen(state_reg.ev1);
                EVENT2_OFS: state_next.rdata = widen(state_reg.ev2);
                EVENT3_OFS: state_next.rdata = widen(state_reg.ev3);
                EVENT4_OFS: state_next.rdata = widen(state_reg.ev4);
                ADJ_A_OFS:  state_next.rdata = widen(state_reg.adj_a);
                ADJ_B_OFS:  state_next.rdata = widen(state_reg.adj_b);
                ADAPT_OFS:  state_next.rdata = widen(state_reg.adapt);
                PHASE_OFS:  state_next.rdata = widen(state_reg.phase);
                STRIG1_OFS: state_next.rdata = widen(state_reg.st1);
                STRIG2_OFS: state_next.rdata = widen(state_reg.st2);
                BLKA_B_OFS: state_next.rdata = widen(state_reg.blka_b);
                BLKA_E_OFS: state_next.rdata = widen(state_reg.blka_e);
                BLKB_B_OFS: state_next.rdata = widen(state_reg.blkb_b);
                BLKB_E_OFS: state_next.rdata = widen(state_reg.blkb_e);
                STATUS_OFS: state_next.rdata = widen(state_reg.count);
                default:    state_next.rdata = UNMAPPED_RD;
            endcase
        end

        // Period counter and per-period capture
        if (!run) begin
            state_next.count = '0;
        end else if (state_reg.count >= state_reg.period_lim) begin
            state_next.count  = '0;
            state_next.pstart = 1'b1;
            // Capture keeps targets stable for the coming period
            state_next.lat_duty   = filt_duty_i;
            state_next.lat_period = (state_reg.ctrl[CTRL_MODE_LSB +: 2] == 2'(PMEG_RESONANT))
                                    ? W'({filt_duty_i, 1'b0}) : filt_period_i;
            state_next.lat_adj_a  = state_reg.adj_a;
            state_next.lat_adj_b  = state_reg.adj_b;
            state_next.lat_adapt  = state_reg.adapt;
            state_next.lat_mode   = pmeg_mode_t'(state_reg.ctrl[CTRL_MODE_LSB +: 2]);
        end else begin
            state_next.count = state_reg.count + W'(1);
        end

        // Trigger pulses at their target counts
        if (run) begin
            state_next.adapt_trig = a_en && (state_reg.count == adapt_pos)
                                    && (state_reg.lat_mode != PMEG_RESONANT);
            state_next.phase_trig = state_reg.count == (state_reg.ctrl[CTRL_PHSRC_BIT]
                                    ? filt_duty_i : state_reg.phase);
            state_next.st1_p = state_reg.count == state_reg.st1;
            state_next.st2_p = state_reg.count == state_reg.st2;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg            <= '0;
            state_reg.ctrl       <= CTRL_RST;
            state_reg.period_lim <= W'(PERIOD_RST);
            state_reg.lat_mode   <= PMEG_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign dat_o          = state_reg.rdata;
    assign ack_o          = state_reg.ack;
    assign output_a_o     = lvl_a;
    assign output_b_o     = lvl_b;
    assign adapt_trig_o   = state_reg.adapt_trig;
    assign phase_trig_o   = state_reg.phase_trig;
    assign samp_trig1_o   = state_reg.st1_p;
    assign samp_trig2_o   = state_reg.st2_p;
    assign blank_a_o      = lvl_ba;
    assign blank_b_o      = lvl_bb;
    assign period_start_o = state_reg.pstart;
endmodule // pmeg_top

// *** tb/pmeg_filter_model.sv ***
// Purpose: Loop filter stand-in feeding duty and period words
// Assumes: Words may change only after a period start
// Notes:   slow_i moves the update one cycle later
module pmeg_filter_model
    import pmeg_pkg::*;
#(
    parameter logic [CNT_W-1:0] PERIOD_WORD = 16'h0063
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             period_start_i,
    input  wire logic             resonant_i,
    input  wire logic             slow_i,
    input  wire logic [CNT_W-1:0] duty_req_i,
    output logic      [CNT_W-1:0] filt_duty_o,
    output logic      [CNT_W-1:0] filt_period_o
);
    // ==========================
    // Word update
    // ==========================
    logic start_d_reg;
    always_ff @(posedge clk_i) begin
        start_d_reg <= period_start_i;
        if (rst_i) begin
            filt_duty_o   <= '0;
            filt_period_o <= PERIOD_WORD;
        end else if (slow_i ? start_d_reg : period_start_i) begin
            filt_duty_o   <= duty_req_i;
            filt_period_o <= resonant_i ? {duty_req_i[CNT_W-2:0], 1'b0} : PERIOD_WORD;
        end
    end
endmodule // pmeg_filter_model

// *** tb/pmeg_monitor.sv ***
// Purpose: Port-level assertions for pmeg_top
// Assumes: Control writes land at the ack edge
// Notes:   Mode is judged two period starts late
module pmeg_monitor
    import pmeg_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    input wire logic        output_a_o,
    input wire logic        adapt_trig_o,
    input wire logic        phase_trig_o,
    input wire logic        samp_trig1_o,
    input wire logic        period_start_o
);
    // ==========================
    // Control shadow
    // ==========================
    logic       en_reg;
    logic       tri_reg;
    logic [1:0] starts_reg;
    logic [8:0] off_reg;
    wire logic  ctrl_wr = cyc_i && stb_i && we_i && ack_o && adr_i == CTRL_OFS;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg     <= 1'b0;
            tri_reg    <= 1'b0;
            starts_reg <= 2'h0;
            off_reg    <= 9'h000;
        end else begin
            if (ctrl_wr) begin
                en_reg     <= dat_i[CTRL_EN_BIT];
                tri_reg    <= dat_i[CTRL_MODE_LSB +: 2] == PMEG_TRIANGLE;
                starts_reg <= 2'h0;
            end else if (period_start_o && starts_reg != 2'h3) begin
                starts_reg <= starts_reg + 2'h1;
            end
            // Settle time after the latched enable is cleared
            off_reg <= (en_reg || ctrl_wr) ? 9'h000 : (off_reg == 9'h12C ? off_reg : off_reg + 9'h001);
        end
    end
    // ==========================
    // Assertions
    // ==========================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
    a_ack_quiet: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
    a_start_pulse: assert property (period_start_o |=> !period_start_o) else $error("start pulse too long");
    a_trig_pulse: assert property ($rose(samp_trig1_o) |=> $fell(samp_trig1_o)) else $error("trigger 1 width");
    a_phase_pulse: assert property (phase_trig_o |-> ##1 !phase_trig_o) else $error("phase pulse width");
    a_off_quiet: assert property (off_reg == 9'h12C |-> !(output_a_o || samp_trig1_o || period_start_o))
        else $error("activity while disabled");
    a_tri_idle: assert property (en_reg && tri_reg && starts_reg[1] |-> !output_a_o && !adapt_trig_o)
        else $error("output a in triangle mode");
endmodule // pmeg_monitor

bind pmeg_top pmeg_monitor pmeg_monitor_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .output_a_o(output_a_o),
    .adapt_trig_o(adapt_trig_o), .phase_trig_o(phase_trig_o), .samp_trig1_o(samp_trig1_o),
    .period_start_o(period_start_o));

// *** tb/pmeg_top_bench.sv ***
// Purpose: Self-checking bench for pmeg_top
// Assumes: Edges are judged inside one period
// Notes:   Edges are timed against output A rise, B rise against A rise or A fall; widths are timed against their own rise
module pmeg_top_bench
    import pmeg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================
    // Harness
    // ==========================
    logic             clk_i;
    logic             rst_i;
    logic             cyc_i;
    logic             stb_i;
    logic             we_i;
    logic [7:0]       adr_i;
    logic [3:0]       sel_i;
    logic [31:0]      dat_i;
    logic [31:0]      dat_o;
    logic             ack_o;
    logic             resonant;
    logic             slow;
    logic [CNT_W-1:0] duty_req;
    logic [CNT_W-1:0] filt_duty;
    logic [CNT_W-1:0] filt_period;
    wire logic [8:0]  sig;
    logic [31:0]      regs[16];
    int               failures;
    int               comparisons;
    int               rise[8];
    int               fall[8];
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    pmeg_top pmeg_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .filt_duty_i(filt_duty),
        .filt_period_i(filt_period), .output_a_o(sig[0]), .output_b_o(sig[1]), .adapt_trig_o(sig[2]),
        .phase_trig_o(sig[3]), .samp_trig1_o(sig[4]), .samp_trig2_o(sig[5]), .blank_a_o(sig[6]),
        .blank_b_o(sig[7]), .period_start_o(sig[8]));
    pmeg_filter_model pmeg_filter_model_inst (.clk_i(clk_i), .rst_i(rst_i), .period_start_i(sig[8]),
        .resonant_i(resonant), .slow_i(slow), .duty_req_i(duty_req), .filt_duty_o(filt_duty),
        .filt_period_o(filt_period));
    // ==========================
    // Shared tasks
    // ==========================
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'hF, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 64);
        q = dat_o;
        {cyc_i, stb_i, sel_i} <= 6'h00;
        if (n >= 64) begin
            failures++;
            report_and_stop();
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(string what, logic [7:0] a, logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(what, q, exp);
    endtask
    task automatic load();
        for (int i = 1; i < 16; i++) wr(8'(4 * i), regs[i]);
        wr(CTRL_OFS, regs[0]);
    endtask
    // Skip periods so new words are latched
    task automatic measure(int skip);
        int t;
        int w;
        int seen;
        logic [8:0] prev;
        {prev, t, w, seen} = {sig, 96'h0};
        rise = '{default: -1};
        fall = '{default: -1};
        while (seen <= skip) begin
            @(posedge clk_i);
            t++;
            if (t > 5000) begin
                failures++;
                report_and_stop();
            end
            if (seen == skip) w++;
            for (int i = 0; i < 8; i++) begin
                if (seen == skip && !prev[i] && sig[i] && rise[i] < 0) rise[i] = w;
                if (seen == skip && prev[i] && !sig[i] && fall[i] < 0) fall[i] = w;
            end
            if (sig[8] === 1'b1) seen++;
            prev = sig;
        end
    endtask
    // ==========================
    // Scenarios
    // ==========================
    task automatic s_regs();
        rd("ctrl", CTRL_OFS, CTRL_RST);
        rd("period", PERIOD_OFS, PERIOD_RST);
        wr(EVENT1_OFS, 32'hABCD_1234);
        rd("event1", EVENT1_OFS, 32'h0000_1234);
        wr(8'h50, 32'h0000_00FF);
        rd("unmapped", 8'h50, UNMAPPED_RD);
        wr(STATUS_OFS, 32'h0000_0055);
        rd("status", STATUS_OFS, ZERO_RST);
    endtask
    task automatic s_normal();
        regs = '{32'h1, 32'h63, 32'hA, 32'h28, 32'h2D, 32'h5A, 32'h3, 32'h7,
                 32'h2, 32'h1E, 32'h32, 32'h3C, 32'h5, 32'hF, 32'h50, 32'h5F};
        load();
        for (int p = 0; p < 2; p++) begin
            measure(3);
            check("a width", fall[0] - rise[0], duty_req + regs[6]);
            check("b rise", rise[1] - fall[0], regs[4] - regs[3]);
            check("b fall", fall[1] - rise[0], regs[5] - regs[2]);
            check("adaptive", rise[2] - rise[0], (p ? duty_req / 2 : duty_req) + regs[8]);
            check("phase", rise[3] - rise[0], (p ? duty_req : regs[9]) - regs[2]);
            check("trig1", rise[4] - rise[0], regs[10] - regs[2]);
            check("trig2", rise[5] - rise[0], regs[11] - regs[2]);
            check("blank a", fall[6] - rise[6], regs[13] - regs[12]);
            check("blank b", rise[7] - rise[0], regs[14] - regs[2]);
            wr(ADJ_B_OFS, 32'h0000_0040);
            wr(CTRL_OFS, 32'h0000_0019);
        end
    endtask
    task automatic s_multi();
        regs[0] = 32'h0000_0003;
        regs[4] = 32'h0000_0032;
        regs[7] = 32'h0000_0004;
        load();
        for (int p = 0; p < 2; p++) begin
            measure(3);
            check("multi a width", fall[0] - rise[0], duty_req + regs[6]);
            check("multi b rise", rise[1] - rise[0], regs[4] - regs[2]);
            check("multi b width", fall[1] - rise[1], duty_req + regs[7]);
            wr(EVENT2_OFS, 32'h0000_004D);
            wr(EVENT4_OFS, 32'h0000_0003);
        end
        wr(EVENT3_OFS, 32'h0000_005A);
        measure(3);
        check("wrap a width", fall[0] - rise[0], duty_req + regs[6]);
        measure(0);
        check("wrap b fall", fall[1] - rise[0], 32'h5A + duty_req + regs[7] - regs[1] - 1 - regs[2]);
    endtask
    task automatic s_resonant();
        int a0;
        regs[0] = 32'h0000_0005;
        regs[4] = 32'h0000_002E;
        regs[5] = 32'h0000_0038;
        resonant <= 1'b1;
        duty_req <= 16'h001E;
        load();
        for (int p = 0; p < 2; p++) begin
            measure(3);
            if (p == 0) a0 = rise[0];
            check("res widths", fall[1] - rise[1], fall[0] - rise[0]);
            check("res width", fall[0] - rise[0],
                  duty_req - ((regs[4] - regs[3]) + (regs[2] + 2 * duty_req - regs[5])) / 2);
            check("res a rise", rise[0], a0);
            check("res dead", rise[1] - fall[0], regs[4] - regs[3]);
            duty_req <= 16'h0028;
        end
    endtask
    task automatic s_tri();
        regs[0] = 32'h0000_0007;
        regs[6] = 32'h0000_0002;
        regs[7] = 32'h0000_0005;
        {resonant, slow} <= 2'h1;
        duty_req <= 16'h0014;
        load();
        measure(3);
        check("tri a", rise[0], -1);
        check("tri adaptive", rise[2], -1);
        check("tri b width", fall[1] - rise[1], duty_req + regs[7] - regs[6]);
        wr(CTRL_OFS, CTRL_RST);
        repeat (320) @(posedge clk_i);
        check("idle outputs", sig, 32'h0000_0000);
        rd("status off", STATUS_OFS, ZERO_RST);
    endtask
    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {4'h8, 44'h0};
        {resonant, slow, duty_req, failures, comparisons} = {2'h0, 16'h0014, 64'h0};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        s_regs();
        s_normal();
        s_multi();
        s_resonant();
        s_tri();
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("ctrl again", CTRL_OFS, CTRL_RST);
        report_and_stop();
    end
endmodule // pmeg_top_bench
